/* design/nvc_ctrl.sv */
// Nested vectored interrupt controller top with Avalon-MM register slave
// Notes on behaviour
// - Four programmable levels, 0 most urgent
// - All programmable levels reset to 0
// - Reset, NMI, hard fault fixed above all
// - Line n reported as vector 16 plus n
// - Lines 0-11 fixed peripheral source order
// - Lines 12-19 serial sources, 16-17 reserved
// - Lines 23,26,28-31 assigned; others reserved
// - Vector table base fixed at zero
// - Word 0 gives initial stack pointer
// - Write-1 set and clear enable registers
// - Disabled line pends but never activates
// - Disabling leaves an active interrupt active
// - Write-1 set and clear pending registers
// - Clear-pending never touches active state
// - Priorities: 8-bit fields, four per line word, three in the system word
// - Preempt only when strictly more urgent
// - Late arrival switches entry without restart
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module nvc_ctrl
    import nvc_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    // Avalon-MM slave
    input  wire logic [6:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [3:0]   avs_byteenable_i,
    input  wire logic [31:0]  avs_writedata_i,
    output logic [31:0]       avs_readdata_o,
    output logic              avs_waitrequest_o,
    // Interrupt sources
    input  nvc_irq_src_t      irq_src_i,
    input  wire logic         nmi_pin_i,
    // Core side
    input  wire logic         fault_evt_i,
    input  wire logic         supervisor_call_exc_evt_i,
    input  wire logic         system_tick_exc_evt_i,
    input  wire logic         core_take_i,
    input  wire logic         entry_done_i,
    input  wire logic         exc_ret_i,
    output logic              exc_req_o,
    output logic [VEC_W-1:0]  exc_vec_o,
    output logic [31:0]       vec_addr_o,
    output logic              irq_o
);

    // ************************************************************
    // State
    // ************************************************************
    logic [31:0]             src_s1_q, src_s2_q;
    logic                    nmi_s1_q, nmi_s2_q, nmi_s3_q;
    logic [NUM_IRQ-1:0]      en_q, en_d;
    logic [NUM_VEC-1:0]      pend_q, pend_d, act_q, act_d;
    logic [NUM_IRQ-1:0][PRIO_W-1:0] prio_q, prio_d;
    logic [2:0][PRIO_W-1:0]  sys_pri_q, sys_pri_d;
    logic [EV_W-1:0]         ev_stat_q, ev_stat_d, ev_en_q, ev_en_d;
    logic                    wait_q, wait_d, irq_q, irq_d;
    logic [31:0]             rdata_q, rdata_d, vaddr_q, vaddr_d;
    nvc_state_t              state_q, state_d;
    logic                    req_q, req_d;
    logic [VEC_W-1:0]        vec_q, vec_d, entry_q, entry_d;
    logic [RANK_W-1:0]       rank_q, rank_d;

    // ************************************************************
    // Ranking
    // ************************************************************
    logic [NUM_VEC-1:0][RANK_W-1:0] rank_all;
    logic [NUM_VEC-1:0]      elig;
    logic                    cand_vld, run_vld;
    logic [VEC_W-1:0]        cand_idx, run_idx;
    logic [RANK_W-1:0]       cand_rank, run_rank;
    logic                    preempt_ok;

    // Rank of every vector
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            rank_all[v] = RANK_NONE;
            if (v >= VEC_IRQ0) begin
                rank_all[v] = nvc_urank(prio_q[v-VEC_IRQ0]);
            end
        end
        rank_all[VEC_NMI]       = RANK_NMI;
        rank_all[VEC_HARDFAULT] = RANK_HF;
        rank_all[VEC_SUPERVISOR_CALL_EXC]    = nvc_urank(sys_pri_q[0]);
        rank_all[VEC_PENDABLE_SERVICE_EXC]    = nvc_urank(sys_pri_q[1]);
        rank_all[VEC_SYSTEM_TICK_EXC]   = nvc_urank(sys_pri_q[2]);
    end

    // Only enabled, inactive pending vectors may be entered
    assign elig = pend_q & ~act_q & {en_q, 16'hFFFF};

    nvc_rank_pick #(.N(NUM_VEC)) u_cand (
        .req_i  (elig),
        .rank_i (rank_all),
        .vld_o  (cand_vld),
        .idx_o  (cand_idx),
        .rank_o (cand_rank)
    );

    nvc_rank_pick #(.N(NUM_VEC)) u_run (
        .req_i  (act_q),
        .rank_i (rank_all),
        .vld_o  (run_vld),
        .idx_o  (run_idx),
        .rank_o (run_rank)
    );

    assign preempt_ok = cand_vld && (cand_rank < run_rank);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic        acc, wr;
    logic [31:0] wmask, sw_set, sw_clr;
    logic [NUM_VEC-1:0] hw_set;
    logic [EV_W-1:0]    ev;
    logic        activate, late;

    assign acc   = (avs_read_i || avs_write_i) && !wait_q;
    assign wr    = avs_write_i && acc;
    assign wmask = avs_writedata_i & {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign sw_set = (wr && avs_address_i == OFF_SET_PEND) ? (wmask & ~RSV_MASK) : '0;
    assign sw_clr = (wr && avs_address_i == OFF_CLR_PEND) ? wmask : '0;

    // Hardware pending sources
    always_comb begin
        hw_set                = '0;
        hw_set[47:16]         = src_s2_q & ~RSV_MASK;
        hw_set[VEC_NMI]       = nmi_s2_q && !nmi_s3_q;
        hw_set[VEC_HARDFAULT] = fault_evt_i;
        hw_set[VEC_SUPERVISOR_CALL_EXC]    = supervisor_call_exc_evt_i;
        hw_set[VEC_SYSTEM_TICK_EXC]   = system_tick_exc_evt_i;
        hw_set[VEC_PENDABLE_SERVICE_EXC]    = wr && avs_address_i == OFF_PSV_CTRL && wmask[0];
    end

    // ************************************************************
    // Entry sequencer
    // ************************************************************
    always_comb begin
        state_d  = state_q;
        req_d    = req_q;
        vec_d    = vec_q;
        rank_d   = rank_q;
        entry_d  = entry_q;
        activate = 1'b0;
        late     = 1'b0;
        case (state_q)
            ST_BOOT_SP: begin
                req_d = 1'b1;
                vec_d = VEC_SP;
                if (core_take_i) begin
                    state_d = ST_BOOT_PC;
                    vec_d   = VEC_RESET;
                    rank_d  = RANK_RESET;
                end
            end
            ST_BOOT_PC: begin
                if (core_take_i) begin
                    state_d = ST_IDLE;
                    req_d   = 1'b0;
                end
            end
            ST_IDLE: begin
                req_d  = preempt_ok;
                vec_d  = cand_idx;
                rank_d = cand_rank;
                if (core_take_i && req_q) begin
                    state_d = ST_ENTRY;
                    entry_d = vec_q;
                    vec_d   = vec_q;
                    rank_d  = rank_q;
                    req_d   = 1'b0;
                end
            end
            ST_ENTRY: begin
                if (entry_done_i) begin
                    activate = elig[entry_q];
                    state_d  = ST_IDLE;
                end else if (cand_vld && cand_rank < rank_q) begin
                    entry_d = cand_idx;
                    vec_d   = cand_idx;
                    rank_d  = cand_rank;
                    late    = 1'b1;
                end
            end
            default: begin
                state_d = ST_BOOT_SP;
            end
        endcase
        vaddr_d = VT_BASE + 32'({vec_d, 2'b00});
    end

    // ************************************************************
    // Pending, active, enable, priority and event state
    // ************************************************************
    always_comb begin
        // Set wins over a same-cycle clear-pending write; activation clears even a same-cycle set
        pend_d         = (pend_q & ~{sw_clr, 16'h0000}) | hw_set | {sw_set, 16'h0000};
        if (wr && avs_address_i == OFF_PSV_CTRL && wmask[1] && !wmask[0]) begin
            pend_d[VEC_PENDABLE_SERVICE_EXC] = hw_set[VEC_PENDABLE_SERVICE_EXC];
        end
        if (activate) begin
            pend_d[entry_q] = 1'b0;
        end
        act_d = act_q;
        if (exc_ret_i && run_vld) begin
            act_d[run_idx] = 1'b0;
        end
        if (activate) begin
            act_d[entry_q] = 1'b1;
        end
        en_d = en_q;
        if (wr && avs_address_i == OFF_SET_EN) begin
            en_d = en_q | (wmask & ~RSV_MASK);
        end
        if (wr && avs_address_i == OFF_CLR_EN) begin
            en_d = en_q & ~wmask;
        end
        prio_d    = prio_q;
        sys_pri_d = sys_pri_q;
        for (int f = 0; f < 4; f++) begin
            if (wr && avs_address_i[6:5] == OFF_PRIO0[6:5] && avs_byteenable_i[f]) begin
                prio_d[4*avs_address_i[4:2]+f] = avs_writedata_i[8*f+PRIO_LSB +: PRIO_W];
            end
            if (f < 3 && wr && avs_address_i == OFF_SYS_PRI && avs_byteenable_i[f]) begin
                sys_pri_d[f] = avs_writedata_i[8*f+PRIO_LSB +: PRIO_W];
            end
        end
        ev               = '0;
        ev[EV_LATE]      = late;
        ev[EV_ACT]       = activate;
        ev[EV_BLOCK]     = |(src_s2_q & ~en_q & ~RSV_MASK);
        ev_stat_d        = ev_stat_q;
        if (wr && avs_address_i == OFF_EV_CLR) begin
            ev_stat_d = ev_stat_q & ~wmask[EV_W-1:0];
        end
        ev_stat_d = ev_stat_d | ev;
        ev_en_d   = (wr && avs_address_i == OFF_EV_EN) ? wmask[EV_W-1:0] : ev_en_q;
        irq_d     = |(ev_stat_d & ev_en_d);
    end

    // ************************************************************
    // Read data and wait
    // ************************************************************
    always_comb begin
        wait_d  = !((avs_read_i || avs_write_i) && wait_q);
        rdata_d = '0;
        case (avs_address_i)
            OFF_SET_EN, OFF_CLR_EN:     rdata_d = en_q;
            OFF_SET_PEND, OFF_CLR_PEND: rdata_d = pend_q[47:16];
            OFF_ACTIVE:                 rdata_d = act_q[47:16];
            OFF_PSV_CTRL: rdata_d = {15'h0000, run_vld, 2'h0, run_idx, 7'h00, pend_q[VEC_PENDABLE_SERVICE_EXC]};
            OFF_EV_STAT:  rdata_d = 32'(ev_stat_q);
            OFF_EV_EN:    rdata_d = 32'(ev_en_q);
            default: begin
                for (int f = 0; f < 4; f++) begin
                    if (avs_address_i[6:5] == OFF_PRIO0[6:5] && avs_address_i[1:0] == 2'h0) begin
                        rdata_d[8*f+PRIO_LSB +: PRIO_W] = prio_q[4*avs_address_i[4:2]+f];
                    end
                    if (f < 3 && avs_address_i == OFF_SYS_PRI) begin
                        rdata_d[8*f+PRIO_LSB +: PRIO_W] = sys_pri_q[f];
                    end
                end
            end
        endcase
        if (!avs_read_i) begin
            rdata_d = rdata_q;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            src_s1_q  <= '0;
            src_s2_q  <= '0;
            nmi_s1_q  <= 1'b0;
            nmi_s2_q  <= 1'b0;
            nmi_s3_q  <= 1'b0;
            en_q      <= '0;
            pend_q    <= '0;
            act_q     <= '0;
            prio_q    <= {NUM_IRQ{PRIO_RST}};
            sys_pri_q <= {3{PRIO_RST}};
            ev_stat_q <= '0;
            ev_en_q   <= '0;
            wait_q    <= 1'b1;
            irq_q     <= 1'b0;
            rdata_q   <= '0;
            vaddr_q   <= VT_BASE;
            state_q   <= ST_BOOT_SP;
            req_q     <= 1'b0;
            vec_q     <= VEC_SP;
            entry_q   <= VEC_SP;
            rank_q    <= RANK_RESET;
        end else begin
            src_s1_q  <= irq_src_i;
            src_s2_q  <= src_s1_q;
            nmi_s1_q  <= nmi_pin_i;
            nmi_s2_q  <= nmi_s1_q;
            nmi_s3_q  <= nmi_s2_q;
            en_q      <= en_d;
            pend_q    <= pend_d;
            act_q     <= act_d;
            prio_q    <= prio_d;
            sys_pri_q <= sys_pri_d;
            ev_stat_q <= ev_stat_d;
            ev_en_q   <= ev_en_d;
            wait_q    <= wait_d;
            irq_q     <= irq_d;
            rdata_q   <= rdata_d;
            vaddr_q   <= vaddr_d;
            state_q   <= state_d;
            req_q     <= req_d;
            vec_q     <= vec_d;
            entry_q   <= entry_d;
            rank_q    <= rank_d;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign exc_req_o         = req_q;
    assign exc_vec_o         = vec_q;
    assign vec_addr_o        = vaddr_q;
    assign irq_o             = irq_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence boot_fetch_s;
        (state_q == ST_BOOT_SP) && (vaddr_q == VT_BASE);
    endsequence

    prio_reset_a: assert property (
        $past(sys_rst_i) |-> (prio_q == '0) && (sys_pri_q == '0))
        else $error("priority not zero after reset");
    boot_sp_a: assert property (
        $fell(sys_rst_i) |-> boot_fetch_s)
        else $error("boot does not fetch stack word");
    vec_addr_a: assert property (
        req_q |-> vaddr_q == VT_BASE + 32'({vec_q, 2'b00}))
        else $error("vector address mismatch");
    nmi_rank_a: assert property (
        (state_q == ST_IDLE && req_q && vec_q >= 6'(VEC_IRQ0)) |-> rank_q >= RANK_USER0)
        else $error("line outranks fixed exceptions");
    preempt_a: assert property (
        (state_q == ST_IDLE && req_q) |-> $past(cand_rank) < $past(run_rank))
        else $error("request without strict urgency");
    late_switch_a: assert property (
        (state_q == ST_ENTRY && !entry_done_i && cand_vld && cand_rank < rank_q)
        |=> state_q == ST_ENTRY && entry_q == $past(cand_idx))
        else $error("late arrival not taken over");
    en_write_a: assert property (
        (wr && avs_address_i == OFF_SET_EN) |=> en_q == ($past(en_q) | ($past(wmask) & ~RSV_MASK)))
        else $error("set-enable write wrong");
    dis_noact_a: assert property (
        1'b1 |=> ((act_q[47:16] & ~$past(act_q[47:16])) & ~$past(en_q)) == '0)
        else $error("disabled line became active");
    act_keep_a: assert property (
        ($past(act_q) & ~act_q) != '0 |-> $past(exc_ret_i))
        else $error("active cleared without return");
    rsv_quiet_a: assert property (
        ((pend_q[47:16] | act_q[47:16]) & RSV_MASK) == '0)
        else $error("reserved line pending or active");
    take_clear_a: assert property (
        activate |=> act_q[$past(entry_q)] && !pend_q[$past(entry_q)] || $past(hw_set[entry_q]))
        else $error("activation left pending set");

endmodule

/* design/nvc_pkg.sv */
// Shared constants, types and helpers of the nested vectored interrupt controller
package nvc_pkg;

    // ************************************************************
    // Sizes and vector numbers
    // ************************************************************
    localparam int NUM_IRQ = 32;
    localparam int NUM_VEC = 48;
    localparam int VEC_W   = 6;
    localparam int RANK_W  = 3;
    localparam int PRIO_W  = 2;

    localparam logic [31:0]      VT_BASE       = 32'h0000_0000;
    localparam logic [VEC_W-1:0] VEC_SP        = 6'h00;
    localparam logic [VEC_W-1:0] VEC_RESET     = 6'h01;
    localparam logic [VEC_W-1:0] VEC_NMI       = 6'h02;
    localparam logic [VEC_W-1:0] VEC_HARDFAULT = 6'h03;
    localparam logic [VEC_W-1:0] VEC_SUPERVISOR_CALL_EXC    = 6'h0B;
    localparam logic [VEC_W-1:0] VEC_PENDABLE_SERVICE_EXC    = 6'h0E;
    localparam logic [VEC_W-1:0] VEC_SYSTEM_TICK_EXC   = 6'h0F;
    localparam int               VEC_IRQ0      = 16;

    // Ranks: 0 is most urgent; fixed -3,-2,-1 map to 0,1,2, user 0..3 to 3..6
    localparam logic [RANK_W-1:0] RANK_RESET = 3'h0;
    localparam logic [RANK_W-1:0] RANK_NMI   = 3'h1;
    localparam logic [RANK_W-1:0] RANK_HF    = 3'h2;
    localparam logic [RANK_W-1:0] RANK_USER0 = 3'h3;
    localparam logic [RANK_W-1:0] RANK_NONE  = 3'h7;

    // ************************************************************
    // Register map (byte addresses) and fields
    // ************************************************************
    localparam logic [6:0] OFF_SET_EN   = 7'h00;
    localparam logic [6:0] OFF_CLR_EN   = 7'h04;
    localparam logic [6:0] OFF_SET_PEND = 7'h08;
    localparam logic [6:0] OFF_CLR_PEND = 7'h0C;
    localparam logic [6:0] OFF_ACTIVE   = 7'h10;
    localparam logic [6:0] OFF_SYS_PRI  = 7'h14;
    localparam logic [6:0] OFF_PSV_CTRL = 7'h18;
    localparam logic [6:0] OFF_PRIO0    = 7'h20;
    localparam logic [6:0] OFF_EV_STAT  = 7'h40;
    localparam logic [6:0] OFF_EV_CLR   = 7'h44;
    localparam logic [6:0] OFF_EV_EN    = 7'h48;
    localparam int         PRIO_LSB     = 6;
    localparam logic [PRIO_W-1:0] PRIO_RST = 2'h0;
    localparam logic [31:0] RSV_MASK    = 32'h0B73_0000;

    // Controller events
    localparam int EV_LATE  = 0;
    localparam int EV_ACT   = 1;
    localparam int EV_BLOCK = 2;
    localparam int EV_W     = 3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_BOOT_SP = 2'b00,
        ST_BOOT_PC = 2'b01,
        ST_IDLE    = 2'b11,
        ST_ENTRY   = 2'b10
    } nvc_state_t;

    // Peripheral lines, line 31 first down to line 0
    typedef struct packed {
        logic       rtc_irq;
        logic       osc_trim_irq;
        logic       adc_irq;
        logic       power_wakeup_irq;
        logic       rsvd27;
        logic       dma_irq;
        logic [1:0] rsvd25_24;
        logic       usb_irq;
        logic [2:0] rsvd22_20;
        logic       two_wire_b_irq;
        logic       two_wire_a_irq;
        logic [1:0] rsvd17_16;
        logic       sync_serial_b_irq;
        logic       sync_serial_a_irq;
        logic       serial_second_irq;
        logic       serial_shared_irq;
        logic       timer_d_irq;
        logic       timer_c_irq;
        logic       timer_b_irq;
        logic       timer_a_irq;
        logic       pulse_group2_irq;
        logic       pulse_group1_irq;
        logic       port_group2_irq;
        logic       port_group1_irq;
        logic       ext_pin_irq_b;
        logic       ext_pin_irq_a;
        logic       watchdog_irq;
        logic       low_voltage_detect_irq;
    } nvc_irq_src_t;

    // User level to rank
    function automatic logic [RANK_W-1:0] nvc_urank(input logic [PRIO_W-1:0] p);
        return RANK_USER0 + RANK_W'(p);
    endfunction

endpackage

/* design/nvc_rank_pick.sv */
// Picks the most urgent requesting vector; lower vector wins a tie
`timescale 1ns/1ps
module nvc_rank_pick
    import nvc_pkg::*;
#(
    parameter int N = NUM_VEC
) (
    // Candidates
    input  wire logic [N-1:0]             req_i,
    input  wire logic [N-1:0][RANK_W-1:0] rank_i,
    // Winner
    output logic                          vld_o,
    output logic [VEC_W-1:0]              idx_o,
    output logic [RANK_W-1:0]             rank_o
);

    // Strict compare keeps the lowest index among equal ranks
    always_comb begin
        vld_o  = 1'b0;
        idx_o  = '0;
        rank_o = RANK_NONE;
        for (int i = 0; i < N; i++) begin
            if (req_i[i] && (rank_i[i] < rank_o)) begin
                vld_o  = 1'b1;
                idx_o  = VEC_W'(i);
                rank_o = rank_i[i];
            end
        end
    end

endmodule

/* dv/nvc_core_model.sv */
// Behavioural processor core that takes requests and completes entries
`timescale 1ns/1ps
module nvc_core_model (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    // Controller side
    input  wire logic       exc_req_i,
    input  wire logic [3:0] dly_i,
    output logic            take_o = 1'b0,
    output logic            done_o = 1'b0
);
    logic [1:0] boot_q = 2'h0;
    logic       busy_q = 1'b0;
    logic [3:0] cnt_q  = 4'h0;

    // Takes each request; the two boot fetches need no entry completion
    always @(posedge sys_clk_i) begin
        take_o <= 1'b0;
        done_o <= 1'b0;
        if (sys_rst_i) begin
            boot_q <= 2'h0;
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
                done_o <= 1'b1;
                busy_q <= 1'b0;
            end
        end else if (exc_req_i && !take_o && !done_o) begin
            take_o <= 1'b1;
            if (boot_q != 2'h2) begin
                boot_q <= boot_q + 2'h1;
            end else begin
                busy_q <= 1'b1;
                cnt_q  <= dly_i;
            end
        end
    end
endmodule

/* dv/nvc_ctrl_tb.sv */
// Self-checking bench of the interrupt controller with a core model
`timescale 1ns/1ps
module nvc_ctrl_tb
    import nvc_pkg::*;
();
    logic              clk   = 1'b0;
    logic              rst   = 1'b1;
    logic              rd    = 1'b0;
    logic              wr    = 1'b0;
    logic              ret   = 1'b0;
    logic [3:0]        dly   = 4'h0;
    logic [6:0]        adr   = 7'h00;
    logic [31:0]       wd    = 32'h0;
    logic [31:0]       lines = 32'h0;
    logic              nmi   = 1'b0;
    logic              flt   = 1'b0;
    nvc_irq_src_t      sp;
    logic [31:0]       q;
    logic [31:0]       rdat;
    logic [31:0]       vad;
    logic [VEC_W-1:0]  vec;
    logic              wq;
    logic              req;
    logic              irq;
    logic              take;
    logic              done;
    int                failures  = 0;
    int                tests_run = 0;
    int                cyc       = 0;

    // ************************************************************
    // Clock, design and core model
    // ************************************************************
    always #2.5 clk = ~clk;

    nvc_ctrl uut (.sys_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
        .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
        .irq_src_i(nvc_irq_src_t'(lines)), .nmi_pin_i(nmi), .fault_evt_i(flt),
        .supervisor_call_exc_evt_i(1'b0), .system_tick_exc_evt_i(1'b0), .core_take_i(take),
        .entry_done_i(done), .exc_ret_i(ret), .exc_req_o(req), .exc_vec_o(vec),
        .vec_addr_o(vad), .irq_o(irq));

    nvc_core_model core (.sys_clk_i(clk), .sys_rst_i(rst), .exc_req_i(req),
        .dly_i(dly), .take_o(take), .done_o(done));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic summarize();
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Avalon-MM access; q holds read data taken at the answering edge
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Pulses peripheral lines long enough to pass the synchroniser
    task automatic pend(input logic [31:0] m);
        lines <= m;
        wt(6);
        lines <= 32'h0;
    endtask

    task automatic retx();
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
    endtask

    // Waits for entry completion and checks the entered vector
    task automatic entry(input logic [VEC_W-1:0] v);
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk);
        chk(32'(vec), 32'(v));
        chk(vad, 32'(v) << 2);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        wt(20);
        rst <= 1'b0;
        wt(2);
        chk(32'({req, vec}), 32'h40);
        wt(10);
        // Named lines sit at their fixed bit positions
        sp                   = '0;
        sp.ext_pin_irq_b     = 1'b1;
        sp.timer_a_irq       = 1'b1;
        sp.serial_shared_irq = 1'b1;
        sp.two_wire_b_irq    = 1'b1;
        sp.usb_irq           = 1'b1;
        sp.dma_irq           = 1'b1;
        sp.rtc_irq           = 1'b1;
        chk(32'(sp), 32'h8488_1108);
        bus(1'b0, OFF_PRIO0, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 7'h3C, 32'hFFFF_FFFF);
        bus(1'b0, 7'h3C, 32'h0);
        chk(q, 32'hC0C0_C0C0);
        bus(1'b1, OFF_SET_EN, 32'hFFFF_FFFF);
        bus(1'b0, OFF_CLR_EN, 32'h0);
        chk(q, 32'hF48C_FFFF);
        bus(1'b1, OFF_CLR_EN, 32'hFFFF_FFFF);
        bus(1'b0, OFF_SET_EN, 32'h0);
        chk(q, 32'h0);
        // Disabled line and reserved line asserted
        bus(1'b1, OFF_EV_EN, 32'h4);
        pend(32'h0001_0100);
        bus(1'b0, OFF_SET_PEND, 32'h0);
        chk(q, 32'h100);
        chk(32'(req), 32'h0);
        chk(32'(irq), 32'h1);
        bus(1'b1, OFF_EV_CLR, 32'h4);
        wt(3);
        chk(32'(irq), 32'h0);
        // Enable the pending line and let it activate
        bus(1'b1, OFF_PRIO0 + 7'h08, 32'h0040_4000);
        bus(1'b1, OFF_SET_EN, 32'h0700);
        entry(6'h18);
        wt(2);
        bus(1'b0, OFF_ACTIVE, 32'h0);
        chk(q, 32'h100);
        bus(1'b0, OFF_SET_PEND, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFF_CLR_EN, 32'h100);
        bus(1'b1, OFF_CLR_PEND, 32'h100);
        bus(1'b0, OFF_ACTIVE, 32'h0);
        chk(q, 32'h100);
        // Less urgent and equally urgent lines do not preempt
        pend(32'h200);
        chk(32'(req), 32'h0);
        retx();
        entry(6'h19);
        pend(32'h400);
        chk(32'(req), 32'h0);
        bus(1'b0, OFF_CLR_PEND, 32'h0);
        chk(q, 32'h400);
        // More urgent line arrives during a slow entry
        dly <= 4'hA;
        bus(1'b1, OFF_SET_EN, 32'h100);
        retx();
        for (int i = 0; i < 40 && take !== 1'b1; i++) @(posedge clk);
        lines <= 32'h100;
        entry(6'h18);
        lines <= 32'h0;
        bus(1'b0, OFF_EV_STAT, 32'h0);
        chk(q, 32'h3);
        // Hard fault pulse and NMI edge driven together, both above the active line
        flt <= 1'b1;
        nmi <= 1'b1;
        @(posedge clk);
        flt <= 1'b0;
        entry(VEC_NMI);
        bus(1'b0, OFF_PSV_CTRL, 32'h0);
        chk(q, 32'h0001_0200);
        retx();
        entry(VEC_HARDFAULT);
        summarize();
    end
endmodule
